/* rtl/spi_defs.svh */
// Register offsets, field positions, reset values and timing counts of the SPI block.
// Assumes byte addresses on an 8-bit APB address bus, one 32-bit word per register.
`ifndef SPI_DEFS_SVH
`define SPI_DEFS_SVH

`define OFF_CTRL1 8'h00
`define OFF_CTRL2 8'h04
`define OFF_DIR 8'h08
`define OFF_STATUS 8'h0c
`define OFF_DATA 8'h10

`define CTRL1_MASK 8'hd7
`define CTRL1_RESET 8'h04
`define CTRL2_DOZE_HALT 0
`define DIR_MISO 0
`define DIR_MOSI 1
`define DIR_SCK 2
`define DIR_SS 3
`define DIR_KEEP_BIDIR 4'h9
`define DIR_KEEP_NORMAL 4'h8
`define STAT_DONE 7
`define STAT_WRITE_COLLISION_FLAG 6
`define STAT_MODE_FAULT_FLAG 4

`define CORE_PERIOD_NS 10
`define SCK_HALF_NS 40
`define SCK_HALF_CLKS (`SCK_HALF_NS / `CORE_PERIOD_NS)
`define WRITE_COLLISION_FLAG_TAIL_CLKS 2'h2
`define LAST_EDGE 4'hf

`endif

/* rtl/spi_pkg.sv */
// Types shared by the SPI block: control layout, pin group and transfer state.
// Assumes spi_defs.svh supplies the numeric constants.
package spi_pkg;

  typedef struct packed {
    logic irq_en_bit;
    logic system_enable_bit;
    logic rsv5;
    logic controller_select_bit;
    logic rsv3;
    logic cpha;
    logic ssoe;
    logic bidir_select_bit;
  } ctrl_one_t;

  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
    logic ss_n;
  } pins_t;

  typedef enum logic {ST_IDLE, ST_SHIFT} xfer_state_t;

endpackage : spi_pkg

/* rtl/spi_sync.sv */
// Two-stage synchroniser for a group of pin levels.
// Assumes the inputs are asynchronous to i_clk; only the second stage is read outside.
`timescale 1ns/1ns
module spi_sync #(
  parameter int WIDTH = 4
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [WIDTH-1:0] i_d,
  output logic [WIDTH-1:0] o_q
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      stage1 <= '1;
      o_q <= '1;
    end else begin
      stage1 <= i_d;
      o_q <= stage1;
    end
  end
endmodule : spi_sync

/* rtl/spi_flag.sv */
// Sticky status flag cleared by a status read seen with the flag set, then a clearing access.
// Assumes strobes are one-cycle APB access-phase pulses on the same clock.
`timescale 1ns/1ns
module spi_flag (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_set,
  input wire logic i_status_read,
  input wire logic i_clear_access,
  output logic o_flag
);
  logic armed;
  wire logic do_clear = i_clear_access & armed;

  // A set in the same cycle as the clear wins, so no event is lost.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_flag <= 1'b0;
      armed <= 1'b0;
    end else begin
      o_flag <= i_set | (o_flag & ~do_clear);
      armed <= ~do_clear & (armed | (i_status_read & o_flag));
    end
  end
endmodule : spi_flag

/* rtl/spi_error_lowpower_flags.sv */
// SPI controller/target with write-collision, mode-fault, low-power and flag handling.
// Assumes an APB master on I_CORE_CLK and SPI pins asynchronous to it.
//
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/1ns
`include "spi_defs.svh"

module spi_error_lowpower_flags
  import spi_pkg::*;
(
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic I_DOZE,
  input wire logic I_STOP,
  output logic O_IRQ,
  input wire logic I_SCK,
  output logic O_SCK,
  output logic O_SCK_OE,
  input wire logic I_MOSI,
  output logic O_MOSI,
  output logic O_MOSI_OE,
  input wire logic I_MISO,
  output logic O_MISO,
  output logic O_MISO_OE,
  input wire logic I_SS_N,
  output logic O_SS_N,
  output logic O_SS_N_OE
);
  ctrl_one_t ctrl;
  logic [7:0] ctrl_two;
  logic [3:0] dir;
  pins_t pin_s;
  xfer_state_t state;
  logic [7:0] shift_reg;
  logic [7:0] rx_data;
  logic rx_bit;
  logic [3:0] edge_idx;
  logic [2:0] div;
  logic sck_out;
  logic sck_prev;
  logic [1:0] tail;
  logic done_flag;
  logic write_collision_flag_flag;
  logic mode_fault_flag_flag;

  // Bus decode; the slave never waits, so every access phase completes at once.
  wire logic setup = I_PSEL & ~I_PENABLE;
  wire logic acc = I_PSEL & I_PENABLE;
  wire logic wr = acc & I_PWRITE;
  wire logic rd = acc & ~I_PWRITE;
  wire logic hit_ctrl1 = I_PADDR == `OFF_CTRL1;
  wire logic hit_ctrl2 = I_PADDR == `OFF_CTRL2;
  wire logic hit_dir = I_PADDR == `OFF_DIR;
  wire logic hit_status = I_PADDR == `OFF_STATUS;
  wire logic hit_data = I_PADDR == `OFF_DATA;
  wire logic mapped = hit_ctrl1 | hit_ctrl2 | hit_dir | hit_status | hit_data;
  wire logic data_wr = wr & hit_data;
  wire logic data_acc = acc & hit_data;
  wire logic status_rd = rd & hit_status;
  wire logic ctrl1_wr = wr & hit_ctrl1;

  spi_sync #(
    .WIDTH(4)
  ) u_pin_sync (
    .i_clk(I_CORE_CLK),
    .i_rst(I_RST),
    .i_d({I_SCK, I_MOSI, I_MISO, I_SS_N}),
    .o_q(pin_s)
  );

  wire logic sys_en = ctrl.system_enable_bit;
  wire logic ctrl_mode = ctrl.controller_select_bit;
  wire logic bidir = ctrl.bidir_select_bit;
  // Stop is treated exactly as doze with the halt bit set.
  wire logic halted = (I_DOZE & ctrl_two[`CTRL2_DOZE_HALT]) | I_STOP;
  wire logic run = sys_en & ~halted;
  wire logic busy = state == ST_SHIFT;

  // The target engine follows the pin clock even when halted, as the far side keeps driving.
  wire logic half_done = div == 3'(`SCK_HALF_CLKS - 1);
  wire logic ctl_edge = run & ctrl_mode & busy & half_done;
  wire logic tgt_sel = sys_en & ~ctrl_mode & ~pin_s.ss_n;
  wire logic tgt_edge = tgt_sel & (pin_s.sck ^ sck_prev);
  wire logic any_edge = ctl_edge | tgt_edge;
  wire logic sample = any_edge & (edge_idx[0] == ctrl.cpha);
  // With phase 1 the first edge only presents the top bit, which already stands on the pin.
  wire logic shift_e = any_edge & (edge_idx[0] != ctrl.cpha)
                       & ~(ctrl.cpha & (edge_idx == 4'h0));
  wire logic last = any_edge & (edge_idx == `LAST_EDGE);
  // Single-pin mode: the controller uses the MOSI pin, the target the MISO pin.
  wire logic rx_in = ctrl_mode ? (bidir ? pin_s.mosi : pin_s.miso)
                               : (bidir ? pin_s.miso : pin_s.mosi);
  wire logic [7:0] rx_byte = {shift_reg[6:0], (ctrl.cpha & last) ? rx_in : rx_bit};
  wire logic done_set = last & ~halted;
  wire logic load_rx = done_set & ~done_flag;

  // Legal write windows for the data register.
  wire logic in_xfer = edge_idx != 4'h0;
  wire logic tgt_ok_ph0 = pin_s.ss_n;
  wire logic tgt_ok_ph1 = ~in_xfer & (tail == `WRITE_COLLISION_FLAG_TAIL_CLKS);
  wire logic wr_legal = ctrl_mode ? ~busy
                                  : (ctrl.cpha ? tgt_ok_ph1 : tgt_ok_ph0);
  wire logic write_collision_flag_set = data_wr & ~wr_legal;

  // A select pin set as output, or as automatic select, cannot signal a fault.
  wire logic mode_fault_flag_evt = sys_en & ctrl_mode & ~dir[`DIR_SS] & ~ctrl.ssoe
                        & ~pin_s.ss_n;
  wire logic [3:0] dir_keep = bidir ? `DIR_KEEP_BIDIR : `DIR_KEEP_NORMAL;
  wire logic [7:0] status_byte = {done_flag, write_collision_flag_flag, 1'b0, mode_fault_flag_flag, 4'h0};

  logic [7:0] rdata;
  always_comb begin
    rdata = 8'h00;
    if (hit_ctrl1) rdata = ctrl;
    if (hit_ctrl2) rdata = ctrl_two;
    if (hit_dir) rdata = {4'h0, dir};
    if (hit_status) rdata = status_byte;
    if (hit_data) rdata = rx_data;
  end

  // Control registers; a mode fault overrides a software write in the same cycle.
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      ctrl <= ctrl_one_t'(`CTRL1_RESET);
      ctrl_two <= 8'h00;
      dir <= 4'h0;
    end else begin
      if (ctrl1_wr) ctrl <= ctrl_one_t'(I_PWDATA[7:0] & `CTRL1_MASK);
      if (wr & hit_ctrl2) ctrl_two <= {7'h00, I_PWDATA[`CTRL2_DOZE_HALT]};
      if (wr & hit_dir) dir <= I_PWDATA[3:0];
      if (mode_fault_flag_evt) begin
        ctrl.system_enable_bit <= 1'b0;
        ctrl.controller_select_bit <= 1'b0;
        dir <= dir & dir_keep;
      end
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      O_PRDATA <= 32'h0000_0000;
    end else if (setup) begin
      O_PRDATA <= {24'h00_0000, rdata};
    end
  end

  // Controller sequencing; while halted the divider, edge count and clock level hold.
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST || !sys_en || mode_fault_flag_evt || !ctrl_mode) begin
      state <= ST_IDLE;
      div <= 3'h0;
      sck_out <= 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (data_wr && wr_legal) state <= ST_SHIFT;
        end
        ST_SHIFT: begin
          if (run) begin
            div <= half_done ? 3'h0 : div + 3'h1;
            if (half_done) sck_out <= ~sck_out;
            if (last) state <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Shift path shared by both roles.
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      shift_reg <= 8'h00;
      rx_bit <= 1'b0;
      edge_idx <= 4'h0;
      sck_prev <= 1'b0;
    end else begin
      sck_prev <= pin_s.sck;
      // With phase 1 the last edge leaves the output bit alone, so the far side samples a settled line.
      if (data_wr && wr_legal) shift_reg <= I_PWDATA[7:0];
      else if (shift_e) shift_reg <= rx_byte;
      if (sample) rx_bit <= rx_in;
      if (!sys_en || (!ctrl_mode && !ctrl.cpha && pin_s.ss_n)) edge_idx <= 4'h0;
      else if (any_edge) edge_idx <= edge_idx + 4'h1;
    end
  end

  // Received data and the trailing guard after the last target edge.
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      rx_data <= 8'h00;
      tail <= `WRITE_COLLISION_FLAG_TAIL_CLKS;
    end else begin
      if (load_rx) rx_data <= rx_byte;
      if (last) tail <= 2'h0;
      else if (tail != `WRITE_COLLISION_FLAG_TAIL_CLKS) tail <= tail + 2'h1;
    end
  end

  spi_flag u_done (
    .i_clk(I_CORE_CLK),
    .i_rst(I_RST),
    .i_set(done_set),
    .i_status_read(status_rd),
    .i_clear_access(data_acc),
    .o_flag(done_flag)
  );

  spi_flag u_write_collision_flag (
    .i_clk(I_CORE_CLK),
    .i_rst(I_RST),
    .i_set(write_collision_flag_set),
    .i_status_read(status_rd),
    .i_clear_access(data_acc),
    .o_flag(write_collision_flag_flag)
  );

  spi_flag u_mode_fault_flag (
    .i_clk(I_CORE_CLK),
    .i_rst(I_RST),
    .i_set(mode_fault_flag_evt),
    .i_status_read(status_rd),
    .i_clear_access(ctrl1_wr),
    .o_flag(mode_fault_flag_flag)
  );

  // The collision flag is deliberately left out of the request.
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) O_IRQ <= 1'b0;
    else O_IRQ <= ctrl.irq_en_bit & (done_flag | mode_fault_flag_flag);
  end

  assign O_PREADY = 1'b1;
  assign O_PSLVERR = acc & ~mapped;
  assign O_SCK = sck_out;
  assign O_MOSI = shift_reg[7];
  assign O_MISO = shift_reg[7];
  assign O_SS_N = ~busy;
  // Cleared direction bits leave the pins as high-impedance inputs.
  assign O_SCK_OE = sys_en & ctrl_mode & dir[`DIR_SCK];
  assign O_MOSI_OE = sys_en & ctrl_mode & dir[`DIR_MOSI];
  assign O_MISO_OE = sys_en & ~ctrl_mode & dir[`DIR_MISO];
  assign O_SS_N_OE = sys_en & ctrl_mode & ctrl.ssoe & dir[`DIR_SS];

  sequence s_tgt_ph1_last;
    last && !ctrl_mode && ctrl.cpha;
  endsequence

  sequence s_status_then_ctrl1;
    (status_rd && mode_fault_flag_flag) ##1 (!mode_fault_flag_evt && !ctrl1_wr)[*2] ##1 (ctrl1_wr && !mode_fault_flag_evt);
  endsequence

  sequence s_status_then_data;
    (status_rd && done_flag) ##1 (!done_set && !data_acc)[*2] ##1 (data_acc && !done_set);
  endsequence

  property p_write_collision_flag_set;
    @(posedge I_CORE_CLK) disable iff (I_RST)
      (data_wr && !wr_legal && !any_edge) |=> write_collision_flag_flag && $stable(shift_reg);
  endproperty
  a_write_collision_flag_set: assert property (p_write_collision_flag_set) else $error("collision not flagged");

  property p_ctrl_busy_write;
    @(posedge I_CORE_CLK) disable iff (I_RST)
      (data_wr && ctrl_mode && busy) |=> write_collision_flag_flag;
  endproperty
  a_ctrl_busy_write: assert property (p_ctrl_busy_write) else $error("busy write ok");

  property p_tail_guard;
    @(posedge I_CORE_CLK) disable iff (I_RST)
      s_tgt_ph1_last ##1 data_wr |=> write_collision_flag_flag;
  endproperty
  a_tail_guard: assert property (p_tail_guard) else $error("early write accepted");

  property p_no_write_collision_flag_irq;
    @(posedge I_CORE_CLK) disable iff (I_RST)
      (!done_flag && !mode_fault_flag_flag) |=> !O_IRQ;
  endproperty
  a_no_write_collision_flag_irq: assert property (p_no_write_collision_flag_irq) else $error("spurious request");

  property p_fault_effect;
    @(posedge I_CORE_CLK) disable iff (I_RST)
      mode_fault_flag_evt |=> mode_fault_flag_flag && !sys_en && !ctrl_mode && dir[`DIR_SCK:`DIR_MOSI] == 2'h0;
  endproperty
  a_fault_effect: assert property (p_fault_effect) else $error("fault not applied");

  property p_bidir_keep;
    @(posedge I_CORE_CLK) disable iff (I_RST)
      (mode_fault_flag_evt && bidir && !(wr && hit_dir)) |=> dir[`DIR_MISO] == $past(dir[`DIR_MISO]);
  endproperty
  a_bidir_keep: assert property (p_bidir_keep) else $error("single pin dir lost");

  property p_halt_freeze;
    @(posedge I_CORE_CLK) disable iff (I_RST)
      (halted && busy && sys_en && ctrl_mode && !mode_fault_flag_evt) |=> $stable(sck_out) && $stable(div);
  endproperty
  a_halt_freeze: assert property (p_halt_freeze) else $error("halted clock moved");

  property p_halt_no_load;
    @(posedge I_CORE_CLK) disable iff (I_RST)
      (last && halted) |=> $stable(rx_data) && (done_flag == $past(done_flag));
  endproperty
  a_halt_no_load: assert property (p_halt_no_load) else $error("halted target loaded");

  property p_done_load;
    @(posedge I_CORE_CLK) disable iff (I_RST)
      (last && !halted && !done_flag) |=> done_flag && rx_data == $past(rx_byte);
  endproperty
  a_done_load: assert property (p_done_load) else $error("byte not loaded");

  property p_done_block;
    @(posedge I_CORE_CLK) disable iff (I_RST)
      (last && done_flag) |=> $stable(rx_data);
  endproperty
  a_done_block: assert property (p_done_block) else $error("data overwritten");

  property p_mode_fault_flag_clear;
    @(posedge I_CORE_CLK) disable iff (I_RST)
      s_status_then_ctrl1 |=> !mode_fault_flag_flag;
  endproperty
  a_mode_fault_flag_clear: assert property (p_mode_fault_flag_clear) else $error("fault flag stuck");

  property p_done_clear;
    @(posedge I_CORE_CLK) disable iff (I_RST)
      s_status_then_data |=> !done_flag;
  endproperty
  a_done_clear: assert property (p_done_clear) else $error("done flag stuck");

endmodule : spi_error_lowpower_flags

/* testbench/spi_remote.sv */
// Far-side SPI party: a target when the block is controller, a controller when it is target.
// Assumes the bench resolves every shared pin and feeds its level back on i_pins.
`timescale 1ns/1ns
module spi_remote
  import spi_pkg::*;
(
  input wire pins_t i_pins,
  output pins_t o_pins
);
  logic [7:0] tgt_tx = 8'h3c;
  logic [7:0] tgt_rx = 8'h00;
  logic [2:0] n = 3'h0;

  initial o_pins = 4'h1;

  always @(posedge i_pins.sck) o_pins.miso <= tgt_tx[~n];

  // After the last bit its hold time runs out, so the line must not keep showing it.
  always @(negedge i_pins.sck) begin
    tgt_rx <= {tgt_rx[6:0], i_pins.mosi};
    n <= n + 3'h1;
    if (n == 3'h7) o_pins.miso <= #60 ~o_pins.miso;
  end

  // The clock only runs inside a frame; data leaves on rising and is taken on falling edges.
  task automatic frame(input logic [7:0] tx, output logic [7:0] rx);
    o_pins.ss_n = 1'b0;
    #250;
    for (int i = 7; i >= 0; i--) begin
      o_pins.mosi = tx[i];
      o_pins.sck = 1'b1;
      #62;
      rx[i] = i_pins.miso;
      o_pins.sck = 1'b0;
      #63;
    end
    #250;
    o_pins.mosi = ~o_pins.mosi;
    o_pins.ss_n = 1'b1;
    #250;
  endtask : frame
endmodule : spi_remote

/* testbench/spi_error_lowpower_flags_bench.sv */
// Self-checking bench: APB register traffic plus an external SPI party on the pins.
// Assumes spi_remote models the far side and that the pins are resolved here.
`timescale 1ns/1ns
`include "spi_defs.svh"
module spi_error_lowpower_flags_bench
  import spi_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic doze = 1'b0;
  logic stop = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdat;
  logic pready, pslverr, serr, irq;
  logic sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, ss_o, ss_oe;
  logic [7:0] last, got;
  int err_count = 0;
  int num_checks = 0;
  pins_t pd, pw;

  assign pw.sck = sck_oe ? sck_o : pd.sck;
  assign pw.mosi = mosi_oe ? mosi_o : pd.mosi;
  assign pw.miso = miso_oe ? miso_o : pd.miso;
  // Where both parties drive select, low wins; a contention raises no fault, as a driven select masks the fault.
  assign pw.ss_n = pd.ss_n & (ss_o | ~ss_oe);

  always #5 clk = ~clk;

  spi_remote remote (.i_pins(pw), .o_pins(pd));

  spi_error_lowpower_flags dut (
    .I_CORE_CLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .I_DOZE(doze), .I_STOP(stop), .O_IRQ(irq),
    .I_SCK(pw.sck), .O_SCK(sck_o), .O_SCK_OE(sck_oe),
    .I_MOSI(pw.mosi), .O_MOSI(mosi_o), .O_MOSI_OE(mosi_oe),
    .I_MISO(pw.miso), .O_MISO(miso_o), .O_MISO_OE(miso_oe),
    .I_SS_N(pw.ss_n), .O_SS_N(ss_o), .O_SS_N_OE(ss_oe)
  );

  task automatic chk(input logic [31:0] got_v, input logic [31:0] exp_v);
    num_checks++;
    if (got_v !== exp_v) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got_v, exp_v);
    end
  endtask : chk

  // An idle cycle follows each transfer so select is never lowered and raised in one step.
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rdat = prdata;
    serr = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 8'h00);
    chk(rdat, e);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic note(input string s);
    $display("%s done, %0d mismatches", s, err_count);
  endtask : note

  task automatic after_reset;
    rd(`OFF_DATA, 32'h0);
    rd(`OFF_STATUS, 32'h0);
    rd(`OFF_CTRL1, 32'h04);
    wr(`OFF_CTRL2, 8'h01);
    rd(`OFF_CTRL2, 32'h1);
    wr(`OFF_CTRL2, 8'h00);
    rd(8'h20, 32'h0);
    chk(serr, 1'b1);
    note("reset state");
  endtask : after_reset

  task automatic ctl_xfer;
    wr(`OFF_DIR, 8'h06);
    wr(`OFF_CTRL1, 8'hd4);
    wr(`OFF_DATA, 8'ha5);
    wr(`OFF_DATA, 8'h11);
    chk(irq, 1'b0);
    for (int t = 0; t < 300 && irq !== 1'b1; t++) @(posedge clk);
    chk(irq, 1'b1);
    rd(`OFF_STATUS, 32'hc0);
    rd(`OFF_DATA, 32'h3c);
    chk(remote.tgt_rx, 8'ha5);
    rd(`OFF_STATUS, 32'h0);
    last = 8'h3c;
    note("controller transfer");
  endtask : ctl_xfer

  // Modes: 0 run, 1 doze without halt, 2 halted doze, 3 stop.
  task automatic tgt(input int m);
    logic [7:0] exp_st;
    exp_st = (m == 0) ? 8'hc0 : (m == 1) ? 8'h80 : 8'h00;
    wr(`OFF_DIR, 8'h01);
    wr(`OFF_CTRL1, 8'h44);
    wr(`OFF_CTRL2, (m == 2) ? 8'h01 : 8'h00);
    wr(`OFF_DATA, 8'h50 + m[7:0]);
    doze <= (m == 1 || m == 2);
    stop <= (m == 3);
    fork
      remote.frame(8'h90 + m[7:0], got);
      begin
        repeat (40) @(posedge clk);
        if (m == 0) wr(`OFF_DATA, 8'hee);
      end
    join
    @(posedge clk);
    chk(got, 8'h50 + m[7:0]);
    rd(`OFF_STATUS, exp_st);
    if (m < 2) last = 8'h90 + m[7:0];
    rd(`OFF_DATA, last);
    rd(`OFF_STATUS, 32'h0);
    doze <= 1'b0;
    stop <= 1'b0;
    note("target transfer");
  endtask : tgt

  task automatic hold_done;
    remote.frame(8'h77, got);
    remote.frame(8'h99, got);
    @(posedge clk);
    rd(`OFF_DATA, 32'h77);
    rd(`OFF_STATUS, 32'h80);
    rd(`OFF_DATA, 32'h77);
    rd(`OFF_STATUS, 32'h0);
    note("done flag hold");
  endtask : hold_done

  task automatic fault(input logic [7:0] b);
    wr(`OFF_DIR, 8'h07);
    wr(`OFF_CTRL1, 8'hd4 | b);
    remote.o_pins.ss_n = 1'b0;
    repeat (8) @(posedge clk);
    chk(irq, 1'b1);
    rd(`OFF_CTRL1, 32'h84 | b);
    rd(`OFF_DIR, {31'h0, b[0]});
    remote.o_pins.ss_n = 1'b1;
    wr(`OFF_CTRL1, 8'h04);
    rd(`OFF_STATUS, 32'h10);
    wr(`OFF_CTRL1, 8'h04);
    rd(`OFF_STATUS, 32'h0);
    note("mode fault");
  endtask : fault

  task automatic masked;
    for (int k = 0; k < 2; k++) begin
      wr(`OFF_DIR, 8'h0e);
      wr(`OFF_CTRL1, k ? 8'h56 : 8'h54);
      remote.o_pins.ss_n = 1'b0;
      repeat (8) @(posedge clk);
      remote.o_pins.ss_n = 1'b1;
      rd(`OFF_STATUS, 32'h0);
      rd(`OFF_CTRL1, k ? 32'h56 : 32'h54);
    end
    note("fault masked");
  endtask : masked

  task automatic test_done;
    $display("%0d checks, %0d mismatches", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    after_reset;
    ctl_xfer;
    for (int m = 0; m < 4; m++) tgt(m);
    hold_done;
    fault(8'h00);
    fault(8'h01);
    masked;
    test_done;
  end

  // The whole run needs some 14 us; this limit only trips on a hang.
  initial begin
    #200000;
    err_count++;
    test_done;
  end
endmodule : spi_error_lowpower_flags_bench
